// [design/dshp_controller.sv]
`timescale 1ns/1ps
// Purpose: dma controller end driving grant, direction and strobe
// Assumes: one transfer per command, requests sampled on sys_clk
// Notes:   strobe pulse and gap each last STROBE_MIN_CYC cycles
module dshp_controller
    import dshp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    dshp_if.controller             pins,
    input  wire logic              single_cycle_transfer_mode,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [DATA_W-1:0] cmd_data,
    output logic                   cmd_ready,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_valid
);
    localparam logic [3:0] SETUP_N  = 4'(SETUP_CYC);
    localparam logic [3:0] STROBE_N = 4'(STROBE_MIN_CYC);

    dshp_state_e       state_ff;
    logic [3:0]        cnt_ff;
    logic              grant_n_ff;
    logic              ds_n_ff;
    logic              dir_ff;
    logic              wr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic              rd_valid_ff;

    assign cmd_ready = (state_ff == DSHP_IDLE);

    // -------------------------------------------------
    // transfer sequencer
    // -------------------------------------------------
    // grant and direction set before the fall, held past the rise
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= DSHP_IDLE;
            cnt_ff      <= '0;
            grant_n_ff  <= 1'b1;
            ds_n_ff     <= 1'b1;
            dir_ff      <= 1'b0;
            wr_ff       <= 1'b0;
            wdata_ff    <= '0;
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
        end else if (clk_en) begin
            rd_valid_ff <= 1'b0;
            case (state_ff)
                DSHP_IDLE: begin
                    if (cmd_valid) begin
                        grant_n_ff <= 1'b0;
                        dir_ff     <= (cmd_write ? DIR_WRITE_NORMAL : ~DIR_WRITE_NORMAL)
                                      ^ single_cycle_transfer_mode;
                        wr_ff      <= cmd_write;
                        wdata_ff   <= cmd_data;
                        cnt_ff     <= SETUP_N;
                        state_ff   <= DSHP_SETUP;
                    end
                end
                DSHP_SETUP: begin
                    if (cnt_ff == 4'h1) begin
                        ds_n_ff  <= 1'b0;
                        cnt_ff   <= STROBE_N;
                        state_ff <= DSHP_STROBE;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                DSHP_STROBE: begin
                    if (cnt_ff == 4'h1) begin
                        ds_n_ff     <= 1'b1;
                        rd_data_ff  <= pins.data_bus;
                        rd_valid_ff <= !wr_ff;
                        cnt_ff      <= STROBE_N;
                        state_ff    <= DSHP_GAP;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                DSHP_GAP: begin
                    if (cnt_ff == 4'h1) begin
                        grant_n_ff <= 1'b1;
                        state_ff   <= DSHP_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                default: begin
                    state_ff <= DSHP_IDLE;
                end
            endcase
        end
    end

    // data driven through strobe and gap so the hold is covered
    assign pins.ctl_data_out   = wdata_ff;
    assign pins.ctl_data_oe    = wr_ff && (state_ff == DSHP_STROBE || state_ff == DSHP_GAP);
    assign pins.dma_grant_in_n = grant_n_ff;
    assign pins.data_strobe_n  = ds_n_ff;
    assign pins.rd_wr_dir      = dir_ff;
    assign pins.chip_sel_n     = 1'b1;
    assign rd_data             = rd_data_ff;
    assign rd_valid            = rd_valid_ff;
endmodule

// [design/dshp_device.sv]
`timescale 1ns/1ps
// Purpose: device end of the dma path on the parallel host port
// Assumes: pins synchronous to sys_clk; controller keeps its timing
// Notes:   mailbox is two fifos, one per direction
//          a read with the tx mailbox empty drives stale data
//          a write with the rx mailbox full drops the word
//          a strobe fall is seen about three cycles after the pin moves
module dshp_device
    import dshp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    dshp_if.device                 pins,
    input  wire logic              bus_style_sel,
    input  wire logic              single_cycle_transfer_mode,
    input  wire logic [DATA_W-1:0] tx_push_data,
    input  wire logic              tx_push_valid,
    output logic                   tx_push_ready,
    output logic      [DATA_W-1:0] rx_pop_data,
    output logic                   rx_pop_valid,
    input  wire logic              rx_pop_ready,
    output logic                   dma_active
);
    logic              ds_sync_ff;
    logic              ds_meta_ff;
    logic              ds_prev_ff;
    logic              grant_meta_ff;
    logic              grant_sync_ff;
    logic              dir_meta_ff;
    logic              dir_sync_ff;
    logic [DATA_W-1:0] data_meta_ff;
    logic [DATA_W-1:0] data_sync_ff;
    logic              ds_mode_ff;
    logic              write_ff;
    logic              in_pulse_ff;
    logic              ds_fall;
    logic              ds_rise;
    logic              is_write;
    logic [DATA_W-1:0] tx_head;
    logic              tx_head_valid;
    logic              tx_pop;
    logic              rx_in_ready;
    logic              rx_push;
    logic [DATA_W-1:0] rd_data_ff;
    logic              rd_oe_ff;
    logic              tx_req_ff;
    logic              rx_req_ff;

    // -------------------------------------------------
    // input synchronisers
    // -------------------------------------------------
    // two stages each; only the second stage is looked at
    // data rides the same two stages, so it lines up with the rise detect
    // grant and direction settle well before the strobe does
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ds_meta_ff    <= 1'b1;
            ds_sync_ff    <= 1'b1;
            ds_prev_ff    <= 1'b1;
            grant_meta_ff <= 1'b1;
            grant_sync_ff <= 1'b1;
            dir_meta_ff   <= 1'b0;
            dir_sync_ff   <= 1'b0;
            data_meta_ff  <= '0;
            data_sync_ff  <= '0;
        end else if (clk_en) begin
            ds_meta_ff    <= pins.data_strobe_n;
            ds_sync_ff    <= ds_meta_ff;
            ds_prev_ff    <= ds_sync_ff;
            grant_meta_ff <= pins.dma_grant_in_n;
            grant_sync_ff <= grant_meta_ff;
            dir_meta_ff   <= pins.rd_wr_dir;
            dir_sync_ff   <= dir_meta_ff;
            data_meta_ff  <= pins.data_bus;
            data_sync_ff  <= data_meta_ff;
        end
    end

    // bus style is a strap level, registered again on every enabled cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ds_mode_ff <= 1'b0;
        end else if (clk_en) begin
            ds_mode_ff <= (bus_style_sel == DS_STYLE_SEL);
        end
    end

    // -------------------------------------------------
    // access decode
    // -------------------------------------------------
    // edge detect resets to the idle high level: no false fall after reset
    // chip select never enters the decode: grant and the bus style qualify
    assign ds_fall  = ds_mode_ff && ds_prev_ff && !ds_sync_ff && !grant_sync_ff;
    assign ds_rise  = in_pulse_ff && ds_sync_ff;
    // inverted direction sense in single-cycle mode
    assign is_write = (dir_sync_ff ^ single_cycle_transfer_mode) == DIR_WRITE_NORMAL;

    // one latched direction per pulse so a single access results
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_pulse_ff <= 1'b0;
            write_ff    <= 1'b0;
        end else if (clk_en) begin
            if (ds_fall) begin
                in_pulse_ff <= 1'b1;
                write_ff    <= is_write;
            end else if (ds_rise) begin
                in_pulse_ff <= 1'b0;
            end
        end
    end

    // level for the user side: high while a strobe pulse is served
    assign dma_active = in_pulse_ff;

    // -------------------------------------------------
    // mailbox fifos
    // -------------------------------------------------
    // write data sampled as strobe rises; rx fifo full drops the word
    assign rx_push = ds_rise && write_ff;
    // read pops the word that was put on the bus at the fall
    assign tx_pop  = ds_fall && !is_write && tx_head_valid;

    // tx mailbox: filled by the user, emptied by dma reads
    dshp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_data   (tx_push_data),
        .in_valid  (tx_push_valid),
        .in_ready  (tx_push_ready),
        .out_data  (tx_head),
        .out_valid (tx_head_valid),
        .out_ready (tx_pop)
    );

    // rx mailbox: filled by dma writes, drained by the user
    dshp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_data   (data_sync_ff),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .out_data  (rx_pop_data),
        .out_valid (rx_pop_valid),
        .out_ready (rx_pop_ready)
    );

    // -------------------------------------------------
    // read data drive
    // -------------------------------------------------
    // driven from the fall, released on the rise
    // oe rises only on a read fall, so the two ends never overlap
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_ff <= '0;
            rd_oe_ff   <= 1'b0;
        end else if (clk_en) begin
            if (ds_fall && !is_write) begin
                rd_data_ff <= tx_head;
                rd_oe_ff   <= 1'b1;
            end else if (ds_rise) begin
                rd_oe_ff   <= 1'b0;
            end
        end
    end

    // bus drive straight from flip-flops
    assign pins.dev_data_out = rd_data_ff;
    assign pins.dev_data_oe  = rd_oe_ff;

    // -------------------------------------------------
    // dma requests
    // -------------------------------------------------
    // tx request: data waiting (excluding word being taken);
    // rx request: room for a word. refreshed each cycle, so
    // an update after a fall lands well inside the 36 ns bound
    // trade-off: one cycle of latency buys glitch-free request pins
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_req_ff <= 1'b0;
            rx_req_ff <= 1'b0;
        end else if (clk_en) begin
            tx_req_ff <= tx_head_valid && !tx_pop;
            rx_req_ff <= rx_in_ready && !(ds_fall && is_write);
        end
    end

    // request pins straight from flip-flops
    assign pins.tx_dma_request = tx_req_ff;
    assign pins.rx_dma_request = rx_req_ff;
endmodule

// [design/dshp_fifo.sv]
`timescale 1ns/1ps
// Purpose: parameterised valid/ready fifo used as the dma mailbox
// Assumes: single clock, clock enable freezes all state
// Notes:   full and empty are exact; simultaneous push and pop allowed
module dshp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    // -------------------------------------------------
    // handshake
    // -------------------------------------------------
    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];

    // storage array, no reset needed on data
    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            if (push && !pop) begin
                count_ff <= count_ff + (AW+1)'(1);
            end else if (pop && !push) begin
                count_ff <= count_ff - (AW+1)'(1);
            end
        end
    end
endmodule

// [dv/dshp_chk.sv]
`timescale 1ns/1ps
// Purpose: concurrent checks on the dma strobe link between the two ends
// Assumes: one shared clock, figures in whole cycles at 200 MHz
// Notes:   sees link pins and the direction mode only
module dshp_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic single_cycle_transfer_mode,
    input wire logic dma_grant_in_n,
    input wire logic data_strobe_n,
    input wire logic rd_wr_dir,
    input wire logic chip_sel_n,
    input wire logic dev_data_oe,
    input wire logic ctl_data_oe
);
    // ----------------------------------------
    // strobe events
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_fall;
        $fell(data_strobe_n);
    endsequence
    sequence s_rise;
        $rose(data_strobe_n);
    endsequence
    // read when the direction level xor mode is high
    sequence s_read_fall;
        $fell(data_strobe_n) && (rd_wr_dir ^ single_cycle_transfer_mode);
    endsequence
    // ----------------------------------------
    // link rules
    // ----------------------------------------
    a_grant_setup: assert property (s_fall |-> $past(dma_grant_in_n) == 1'b0)
        else $error("grant not set up before strobe fall");
    a_grant_hold: assert property (s_rise |-> !dma_grant_in_n [*2])
        else $error("grant dropped at strobe rise");
    a_dir_stable: assert property (!data_strobe_n |-> $stable(rd_wr_dir))
        else $error("direction moved during strobe");
    a_pulse_width: assert property (s_fall |-> !data_strobe_n [*6])
        else $error("strobe pulse too short");
    a_gap_width: assert property (s_rise |-> data_strobe_n [*6])
        else $error("strobe gap too short");
    a_read_drive: assert property (s_read_fall |-> ##[1:4] dev_data_oe)
        else $error("read data not driven in time");
    a_read_hold: assert property (dev_data_oe && !data_strobe_n |=> dev_data_oe)
        else $error("read data released during strobe");
    a_read_release: assert property ((s_rise and dev_data_oe) |-> ##[1:4] !dev_data_oe)
        else $error("read data not released after strobe rise");
    a_dev_dir: assert property (dev_data_oe && !data_strobe_n |-> rd_wr_dir ^ single_cycle_transfer_mode)
        else $error("device drives bus on a write");
    a_ctl_dir: assert property (ctl_data_oe && !data_strobe_n |-> !(rd_wr_dir ^ single_cycle_transfer_mode))
        else $error("controller drives bus on a read");
    a_no_clash: assert property (!(dev_data_oe && ctl_data_oe))
        else $error("both ends drive the bus");
    a_oe_granted: assert property (dev_data_oe |-> !dma_grant_in_n)
        else $error("device drives bus without grant");
    a_cs_unused: assert property (chip_sel_n == 1'b1)
        else $error("chip select asserted during dma");
endmodule

// [dv/test_dma_strobe_host_port.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench joining device and controller ends
// Assumes: one 200 MHz clock, inputs driven at the falling edge
// Notes:   driver queues expected bytes, a monitor checks them
module test_dma_strobe_host_port
    import dshp_pkg::*;
;
    logic              sys_clk, rst_b, clk_en, bus_style_sel, scm_mode;
    logic [DATA_W-1:0] tx_push_data, rx_pop_data, cmd_data, rd_data, d;
    logic              tx_push_valid, tx_push_ready, rx_pop_valid, rx_pop_ready;
    logic              cmd_valid, cmd_write, cmd_ready, rd_valid, dma_active;
    int                num_errors, n_checks, cnt;
    logic [DATA_W-1:0] exp_rd[$];
    logic [DATA_W-1:0] exp_rx[$];

    dshp_if dshp_if_inst ();
    dshp_device dshp_device_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .pins(dshp_if_inst),
        .bus_style_sel(bus_style_sel), .single_cycle_transfer_mode(scm_mode), .tx_push_data(tx_push_data),
        .tx_push_valid(tx_push_valid), .tx_push_ready(tx_push_ready), .rx_pop_data(rx_pop_data),
        .rx_pop_valid(rx_pop_valid), .rx_pop_ready(rx_pop_ready), .dma_active(dma_active));
    dshp_controller dshp_controller_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .pins(dshp_if_inst), .single_cycle_transfer_mode(scm_mode), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid));
    dshp_chk dshp_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b), .single_cycle_transfer_mode(scm_mode),
        .dma_grant_in_n(dshp_if_inst.dma_grant_in_n), .data_strobe_n(dshp_if_inst.data_strobe_n),
        .rd_wr_dir(dshp_if_inst.rd_wr_dir), .chip_sel_n(dshp_if_inst.chip_sel_n),
        .dev_data_oe(dshp_if_inst.dev_data_oe), .ctl_data_oe(dshp_if_inst.ctl_data_oe));

    // ----------------------------------------
    // clock, checking and closing
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // a hang is cut short here rather than left to run forever
    task automatic guard(input int k);
        if (k >= 300) begin
            check("wait_bound", 8'h01, 8'h00);
            results();
        end
    endtask
    // monitor: every result takes the oldest note; an empty queue yields x and fails
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) check("rd_data", rd_data, exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hxx);
        if (rx_pop_valid === 1'b1 && rx_pop_ready === 1'b1)
            check("rx_pop_data", rx_pop_data, exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hxx);
    end

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    // one controller transfer; stall freezes both ends mid-transfer
    task automatic do_cmd(input logic wr, input logic [7:0] val, input logic stall);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        guard(k);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_data = val;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        if (stall) begin
            repeat (3) @(negedge sys_clk);
            clk_en = 1'b0;
            repeat (10) @(negedge sys_clk);
            clk_en = 1'b1;
        end else begin
            // mid-pulse: busy only when the strobe style is selected
            repeat (6) @(negedge sys_clk);
            check("dma_active", dma_active, {7'h00, bus_style_sel});
        end
        k = 0;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1 && k < 300) begin
            @(negedge sys_clk);
            k++;
        end
        guard(k);
        repeat (2) @(negedge sys_clk);
    endtask
    // one low cycle after each word, so valid is never set twice at once
    task automatic push_tx(input logic [7:0] val);
        tx_push_valid = 1'b1;
        tx_push_data = val;
        @(negedge sys_clk);
        tx_push_valid = 1'b0;
        @(negedge sys_clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {rst_b, tx_push_valid, cmd_valid, cmd_write, scm_mode} = 5'b0_0000;
        {clk_en, bus_style_sel, rx_pop_ready} = 3'b111;
        {tx_push_data, cmd_data} = 16'h0000;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(18113));
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("tx_req_reset", dshp_if_inst.tx_dma_request, 8'h00);
        check("rx_req_reset", dshp_if_inst.rx_dma_request, 8'h01);
        check("dev_oe_reset", dshp_if_inst.dev_data_oe, 8'h00);
        // both direction encodings: writes, then reads of queued bytes
        for (int m = 0; m < 2; m++) begin
            scm_mode = m[0];
            for (int i = 0; i < 3; i++) begin
                d = 8'($urandom);
                exp_rx.push_back(d);
                do_cmd(1'b1, d, m == 1 && i == 0);
            end
            for (int i = 0; i < 3; i++) begin
                d = 8'($urandom);
                exp_rd.push_back(d);
                push_tx(d);
            end
            repeat (2) @(negedge sys_clk);
            check("tx_req_pending", dshp_if_inst.tx_dma_request, 8'h01);
            for (int i = 0; i < 3; i++) do_cmd(1'b0, 8'($urandom), 1'b0);
            check("tx_req_empty", dshp_if_inst.tx_dma_request, 8'h00);
        end
        // mode pin low: the strobe must not reach the mailbox
        bus_style_sel = 1'b0;
        do_cmd(1'b1, 8'($urandom), 1'b0);
        check("rx_valid_off", rx_pop_valid, 8'h00);
        bus_style_sel = 1'b1;
        // rx mailbox filled past its depth; extra word is dropped
        rx_pop_ready = 1'b0;
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            d = 8'($urandom);
            if (i < FIFO_DEPTH) exp_rx.push_back(d);
            do_cmd(1'b1, d, 1'b0);
        end
        // full rx mailbox withdraws its request
        check("rx_req_full", dshp_if_inst.rx_dma_request, 8'h00);
        // drain with the user side stalling at random
        cnt = 0;
        while (rx_pop_valid === 1'b1 && cnt < 300) begin
            rx_pop_ready = 1'($urandom);
            @(negedge sys_clk);
            cnt++;
        end
        rx_pop_ready = 1'b1;
        check("rx_left", 8'(exp_rx.size()), 8'h00);
        // tx mailbox filled until refused, then read out
        cnt = 0;
        while (tx_push_ready === 1'b1 && cnt < 40) begin
            d = 8'($urandom);
            exp_rd.push_back(d);
            push_tx(d);
            cnt++;
        end
        check("tx_depth", 8'(cnt), 8'(FIFO_DEPTH));
        for (int i = 0; i < FIFO_DEPTH; i++) do_cmd(1'b0, 8'($urandom), 1'b0);
        check("rd_left", 8'(exp_rd.size()), 8'h00);
        check("tx_req_drained", dshp_if_inst.tx_dma_request, 8'h00);
        results();
    end
    initial begin
        #300000;
        check("run_bound", 8'h01, 8'h00);
        results();
    end
endmodule

// [include/dshp_if.sv]
`timescale 1ns/1ps
// Purpose: pin bundle between the device port and the dma controller
// Assumes: single shared clock, both ends sample pins synchronously
// Notes:   data bus is split into in/out/enable; wire level resolved here
interface dshp_if;
    logic       dma_grant_in_n;
    logic       data_strobe_n;
    logic       rd_wr_dir;
    logic       chip_sel_n;
    logic       tx_dma_request;
    logic       rx_dma_request;
    logic [7:0] dev_data_out;
    logic       dev_data_oe;
    logic [7:0] ctl_data_out;
    logic       ctl_data_oe;
    logic [7:0] data_bus;

    // wired data bus: whichever end enables wins, the device if both do, else held low
    assign data_bus = dev_data_oe ? dev_data_out : (ctl_data_oe ? ctl_data_out : 8'h00);

    modport device (
        input  dma_grant_in_n,
        input  data_strobe_n,
        input  rd_wr_dir,
        input  chip_sel_n,
        input  data_bus,
        output tx_dma_request,
        output rx_dma_request,
        output dev_data_out,
        output dev_data_oe
    );
    modport controller (
        output dma_grant_in_n,
        output data_strobe_n,
        output rd_wr_dir,
        output chip_sel_n,
        input  data_bus,
        input  tx_dma_request,
        input  rx_dma_request,
        output ctl_data_out,
        output ctl_data_oe
    );
endinterface

// [include/dshp_pkg.sv]
// Purpose: shared constants and types for the dma strobe host port
// Assumes: core clock of 200 MHz, all port pins sampled on sys_clk
// Notes:   widths fixed; timing counts derived from printed times
package dshp_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_PERIOD_PS = 5000;
    // least strobe width and gap, rounded up to whole cycles
    localparam int STROBE_MIN_PS = 30000;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // longest request update delay, rounded down
    localparam int REQ_DLY_PS = 36000;
    localparam int REQ_DLY_CYC = REQ_DLY_PS / CLK_PERIOD_PS;
    // setup of grant and direction ahead of the strobe, rounded up
    localparam int SETUP_PS = 7000;
    localparam int SETUP_CYC = (SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // direction level that marks a write in normal mode
    localparam logic DIR_WRITE_NORMAL = 1'b0;
    localparam logic DS_STYLE_SEL = 1'b1;
    typedef enum logic [1:0] {
        DSHP_IDLE,
        DSHP_SETUP,
        DSHP_STROBE,
        DSHP_GAP
    } dshp_state_e;
endpackage
